// ==== logic/aux_io_consts.svh ====
// Constants for the auxiliary level, pin control and misc control block.
// Assumes a 50 MHz system clock and 7-bit SPI byte addresses.
`ifndef AUX_IO_CONSTS_SVH
`define AUX_IO_CONSTS_SVH

// Byte addresses of the register words (low byte of each pair)
`define ADDR_AUX_LEVEL   7'h30
`define ADDR_PIN_IO      7'h32
`define ADDR_MISC_CTRL   7'h34
`define ADDR_STATUS      7'h3C
`define ADDR_COMMAND     7'h3E

// Reset values and writable masks
`define REG_RESET        16'h0000
`define MASK_AUX_LEVEL   16'h0FFF
`define MASK_PIN_IO      16'h0303
`define MASK_MISC_CTRL   16'h0307

// Field positions
`define PIN_DIR0         0
`define PIN_LVL0         8
`define MISC_DR_SEL      0
`define MISC_DR_POL      1
`define MISC_DR_EN       2
`define MISC_POS_ROT     8
`define MISC_NEG_ROT     9
`define MISC_ST_START    10
`define STAT_ST_ERR      5
`define CMD_DAC_LATCH    2

// Timing
`define CLK_KHZ          50000
`define ST_TIME_MS       35
`define DR_CNT_W         29
`define DR_DUTY_SHIFT    2

`endif

// ==== logic/aux_io_dataready_selftest_ctrl.sv ====
// Auxiliary level latch, two I/O lines, data-ready pulse and self-test
// control of a rate sensor, reached over SPI.
// Assumes sampleTick, alarm and self-test result inputs are on sys_clk.
//
// Notes on behaviour
// [R1] The auxiliary level register keeps a 12-bit value with the top four bits unused.
// [R2] Byte writes to the level register leave the applied level alone until the latch command.
// [R3] The level register and applied level clear on every reset and the host must reload them.
// [R4] Pin control bits 0 and 1 set line zero and line one to output when one, input when zero.
// [R5] Pin control bits 8 and 9 give the driven level of line zero and line one as outputs.
// [R6] A read of pin control shows the sampled pin level in bits 0 and 1 for input lines.
// [R7] Data-ready claims a line first, then the alarm engine, then plain pin control.
// [R8] Misc control bit 2 enables data-ready and bit 1 picks active high when set.
// [R9] Misc control bit 0 sends data-ready to line one when set, line zero when clear.
// [R10] Each output update gives a data-ready pulse of a quarter of the update period.
// [R11] Writing one to misc bit 10 starts the internal test; the host reads status bit 5 after 35 ms.
// [R12] Misc bits 9 and 8 hold the negative and positive external test stimulus while set.
// [R13] The host should run the internal test at full bandwidth with least filtering.
// [R14] Writing one to command bit 2 copies the level register into the applied level.
// [R15] The self-test error flag in status stays set until a status read clears it; a new error in the same cycle wins over the read.
// [R16] Unused bits of the three control registers read as zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "aux_io_consts.svh"

module aux_io_dataready_selftest_ctrl
  import aux_io_pkg::*;
#(
  parameter logic [21:0] SELFTEST_CYC = 22'(`ST_TIME_MS * `CLK_KHZ)
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        mosi,
  output logic             miso,
  input  wire logic [1:0]  ioIn,
  output logic      [1:0]  ioOut,
  output logic      [1:0]  ioOe,
  input  wire logic        sampleTick,
  input  wire logic [1:0]  alarmOwn,
  input  wire logic [1:0]  alarmLevel,
  input  wire logic        selfTestFail,
  output logic      [11:0] dacLevel,
  output logic             selfTestRun,
  output logic             negRotTest,
  output logic             posRotTest
);

  spiFrame_s             frame;
  pinDrive_s             pinNext;
  logic [15:0]           auxLevel_q;
  logic [15:0]           pinCtrl_q;
  logic [15:0]           miscCtrl_q;
  logic [1:0]            ioInMeta_q;
  logic [1:0]            ioInSync_q;
  logic [15:0]           rdWord;
  logic                  wrEven;
  logic                  wrOdd;
  logic                  latchCmd;
  logic                  stStart;
  logic                  stEnd;
  logic [21:0]           stTimer_q;
  logic                  stErr_q;
  logic                  statusRead;
  logic [`DR_CNT_W-1:0]  drCount_q;
  logic [`DR_CNT_W-1:0]  drLeft_q;
  logic                  drActive;
  logic                  drLevel;

  // Word base of a byte address
  function automatic logic [6:0] wordOf(input logic [6:0] a);
    wordOf = {a[6:1], 1'b0};
  endfunction : wordOf

  // Byte write into a word register under its writable mask
  function automatic logic [15:0] byteWrite(input logic [15:0] cur,
                                            input logic [15:0] mask,
                                            input logic        hi,
                                            input logic [7:0]  data);
    logic [15:0] nxt;
    nxt = hi ? {data, cur[7:0]} : {cur[15:8], data};
    byteWrite = nxt & mask;
  endfunction : byteWrite

  spi_frame_slave u_spi (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .ce      (ce),
    .sclk    (sclk),
    .csN     (csN),
    .mosi    (mosi),
    .miso    (miso),
    .frame   (frame),
    .rdWord  (rdWord)
  );

  // Write strobes and command decode
  assign wrEven     = frame.valid & frame.write & ~frame.addr[0];
  assign wrOdd      = frame.valid & frame.write & frame.addr[0];
  assign latchCmd   = wrEven & (frame.addr == `ADDR_COMMAND)
                      & frame.data[`CMD_DAC_LATCH];                  // R14
  assign stStart    = wrOdd & (frame.addr == (`ADDR_MISC_CTRL + 7'h01))
                      & frame.data[`MISC_ST_START - 8];              // R11
  assign statusRead = frame.valid & ~frame.write
                      & (wordOf(frame.addr) == `ADDR_STATUS);

  // Level, pin control and misc control registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      auxLevel_q <= `REG_RESET;                                      // R3
      pinCtrl_q  <= `REG_RESET;
      miscCtrl_q <= `REG_RESET;
    end else if (ce && frame.valid && frame.write) begin
      unique case (wordOf(frame.addr))
        `ADDR_AUX_LEVEL: auxLevel_q <= byteWrite(auxLevel_q,
            `MASK_AUX_LEVEL, frame.addr[0], frame.data);             // R1 R16
        `ADDR_PIN_IO:    pinCtrl_q  <= byteWrite(pinCtrl_q,
            `MASK_PIN_IO, frame.addr[0], frame.data);                // R4 R5
        `ADDR_MISC_CTRL: miscCtrl_q <= byteWrite(miscCtrl_q,
            `MASK_MISC_CTRL, frame.addr[0], frame.data);             // R8 R12
        default: ;
      endcase
    end
  end

  // Applied level moves only on the latch command
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dacLevel <= 12'h000;                                           // R3
    end else if (ce && latchCmd) begin
      dacLevel <= auxLevel_q[11:0];                                  // R2 R14
    end
  end

  // External test stimulus follows the static enables
  assign negRotTest = miscCtrl_q[`MISC_NEG_ROT];                     // R12
  assign posRotTest = miscCtrl_q[`MISC_POS_ROT];                     // R12

  // Internal test timer; run bit reads back as misc bit 10
  assign stEnd = selfTestRun & (stTimer_q == 22'h000001);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      selfTestRun <= 1'b0;
      stTimer_q   <= 22'h000000;
    end else if (ce) begin
      if (stStart && !selfTestRun) begin
        selfTestRun <= 1'b1;                                         // R11
        stTimer_q   <= SELFTEST_CYC;
      end else if (stEnd) begin
        selfTestRun <= 1'b0;
        stTimer_q   <= 22'h000000;
      end else if (selfTestRun) begin
        stTimer_q <= stTimer_q - 22'h000001;
      end
    end
  end

  // Sticky error flag; a new error wins over a status read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stErr_q <= 1'b0;
    end else if (ce) begin
      if (stEnd && selfTestFail) begin
        stErr_q <= 1'b1;                                             // R15
      end else if (statusRead) begin
        stErr_q <= 1'b0;                                             // R15
      end
    end
  end

  // Update period measure and pulse length of a quarter period
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      drCount_q <= '0;
      drLeft_q  <= '0;
    end else if (ce) begin
      if (sampleTick) begin
        drCount_q <= `DR_CNT_W'(1);
        drLeft_q  <= ((drCount_q >> `DR_DUTY_SHIFT) == '0) ?
                     `DR_CNT_W'(1) : (drCount_q >> `DR_DUTY_SHIFT);  // R10
      end else begin
        if (drCount_q != '1) begin
          drCount_q <= drCount_q + `DR_CNT_W'(1);
        end
        if (drLeft_q != '0) begin
          drLeft_q <= drLeft_q - `DR_CNT_W'(1);
        end
      end
    end
  end

  assign drActive = (drLeft_q != '0);
  assign drLevel  = ~(drActive ^ miscCtrl_q[`MISC_DR_POL]);          // R8

  // Pin owner priority: data-ready, then alarm, then pin control
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (miscCtrl_q[`MISC_DR_EN] &&
          (miscCtrl_q[`MISC_DR_SEL] == 1'(i))) begin                 // R7 R9
        pinNext.enable[i] = 1'b1;
        pinNext.level[i]  = drLevel;
      end else if (alarmOwn[i]) begin                                // R7
        pinNext.enable[i] = 1'b1;
        pinNext.level[i]  = alarmLevel[i];
      end else begin
        pinNext.enable[i] = pinCtrl_q[`PIN_DIR0 + i];                // R4
        pinNext.level[i]  = pinCtrl_q[`PIN_LVL0 + i];                // R5
      end
    end
  end

  // Registered pin drive and synchronised pin sampling
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ioOut      <= 2'h0;
      ioOe       <= 2'h0;
      ioInMeta_q <= 2'h0;
      ioInSync_q <= 2'h0;
    end else if (ce) begin
      ioOut      <= pinNext.level & pinNext.enable;
      ioOe       <= pinNext.enable;
      ioInMeta_q <= ioIn;
      ioInSync_q <= ioInMeta_q;
    end
  end

  // Read data for the reply frame
  always_comb begin
    unique case (wordOf(frame.addr))
      `ADDR_AUX_LEVEL: rdWord = auxLevel_q;                          // R16
      `ADDR_PIN_IO:    rdWord = pinCtrl_q
                         | {14'h0000, ~pinCtrl_q[1:0] & ioInSync_q}; // R6
      `ADDR_MISC_CTRL: rdWord = miscCtrl_q
                         | ({15'h0000, selfTestRun} << `MISC_ST_START);
      `ADDR_STATUS:    rdWord = {15'h0000, stErr_q} << `STAT_ST_ERR;
      default:         rdWord = 16'h0000;
    endcase
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Level register, latch and unused register bits
  a_level_holds: assert property (                                   // R2
    ce && !latchCmd |=> $stable(dacLevel))
    else $error("applied level moved without latch command");
  a_latch_loads: assert property (                                   // R14
    ce && latchCmd |=> dacLevel == $past(auxLevel_q[11:0]))
    else $error("latch command did not load level");
  a_level_upper: assert property (                                   // R1
    auxLevel_q[15:12] == 4'h0 && pinCtrl_q[7:2] == 6'h00)
    else $error("unused level or pin bits set");
  a_misc_unused: assert property (                                   // R16
    miscCtrl_q[15:10] == 6'h00 && miscCtrl_q[7:3] == 5'h00)
    else $error("unused misc control bits set");

  // Line ownership and data-ready shape
  a_pin_gpio: assert property (                                      // R4
    ce && !miscCtrl_q[`MISC_DR_EN] && !alarmOwn[0] |=>
      ioOe[0] == $past(pinCtrl_q[0]) &&
      ioOut[0] == $past(pinCtrl_q[8] & pinCtrl_q[0]))
    else $error("line zero does not follow pin control");
  a_pin_dr_first: assert property (                                  // R7
    ce && miscCtrl_q[`MISC_DR_EN] && miscCtrl_q[`MISC_DR_SEL] |=>
      ioOe[1] && ioOut[1] == $past(drLevel))
    else $error("data-ready lost line one to another owner");
  a_dr_route: assert property (                                      // R9
    ce && miscCtrl_q[`MISC_DR_EN] && !miscCtrl_q[`MISC_DR_SEL] |=>
      ioOe[0] && ioOut[0] == $past(drLevel))
    else $error("data-ready not routed to line zero");
  a_dr_active: assert property (                                     // R8
    drActive |-> drLevel == miscCtrl_q[`MISC_DR_POL])
    else $error("data-ready active level wrong");
  a_dr_idle: assert property (                                       // R8
    !drActive |-> drLevel != miscCtrl_q[`MISC_DR_POL])
    else $error("data-ready idle level wrong");
  a_dr_pulse: assert property (                                      // R10
    ce && sampleTick && drCount_q >= `DR_CNT_W'(8) |=>
      drLeft_q == $past(drCount_q >> `DR_DUTY_SHIFT))
    else $error("data-ready pulse not a quarter period");
  a_dr_nonzero: assert property (                                    // R10
    ce && sampleTick |=> drLeft_q != '0)
    else $error("data-ready pulse missing after update");

  // Internal test and error flag
  a_st_runs: assert property (                                       // R11
    ce && stStart && !selfTestRun |=> selfTestRun[*2])
    else $error("internal test did not start");
  a_st_length: assert property (                                     // R11
    ce && stStart && !selfTestRun |=> stTimer_q == SELFTEST_CYC)
    else $error("internal test timer not loaded");
  a_st_sticky: assert property (                                     // R15
    stErr_q && !statusRead |=> stErr_q)
    else $error("error flag cleared without status read");
  a_st_clear: assert property (                                      // R15
    ce && statusRead && !stEnd |=> !stErr_q)
    else $error("status read did not clear error flag");

  // Main scenarios
  c_latch: cover property (ce && latchCmd);
  c_dr_pulse: cover property ($rose(drActive) && miscCtrl_q[`MISC_DR_EN]);
  c_st_error: cover property ($rose(stErr_q));
  c_st_clear: cover property ($fell(stErr_q));

endmodule : aux_io_dataready_selftest_ctrl
`default_nettype wire

// ==== logic/aux_io_pkg.sv ====
// Types shared by the SPI front end and the control block.
// Assumes the constants header is included by the modules.
package aux_io_pkg;

  // One received SPI frame
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } spiFrame_s;

  // Drive of the two I/O lines
  typedef struct packed {
    logic [1:0] level;
    logic [1:0] enable;
  } pinDrive_s;

endpackage : aux_io_pkg

// ==== logic/spi_frame_slave.sv ====
// SPI slave front end: 16-bit frames, mode 3, sampled by the system clock.
// Assumes the serial clock is far slower than sys_clk (at least 8x).
`timescale 1ns/10ps
`default_nettype none
`include "aux_io_consts.svh"

module spi_frame_slave
  import aux_io_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        mosi,
  output logic             miso,
  output spiFrame_s        frame,
  input  wire logic [15:0] rdWord
);

  logic [2:0]  sclkPipe_q;
  logic [2:0]  csPipe_q;
  logic [1:0]  mosiPipe_q;
  logic [3:0]  bitCnt_q;
  logic [15:0] rxShift_q;
  logic [15:0] txShift_q;
  logic        rise;
  logic        csLow;

  // Two-stage synchronisers plus one delay stage for edge finding
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPipe_q <= 3'h7;
      csPipe_q   <= 3'h7;
      mosiPipe_q <= 2'h0;
    end else if (ce) begin
      sclkPipe_q <= {sclkPipe_q[1:0], sclk};
      csPipe_q   <= {csPipe_q[1:0], csN};
      mosiPipe_q <= {mosiPipe_q[0], mosi};
    end
  end

  assign rise  = sclkPipe_q[1] & ~sclkPipe_q[2];
  assign csLow = ~csPipe_q[1];

  // Receive shifter and bit count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt_q  <= 4'h0;
      rxShift_q <= 16'h0000;
    end else if (ce) begin
      if (!csLow) begin
        bitCnt_q <= 4'h0;
      end else if (rise) begin
        rxShift_q <= {rxShift_q[14:0], mosiPipe_q[1]};
        bitCnt_q  <= bitCnt_q + 4'h1;
      end
    end
  end

  // Frame strobe after the sixteenth rising edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame <= '0;
    end else if (ce) begin
      frame.valid <= csLow & rise & (bitCnt_q == 4'hF);
      if (csLow & rise & (bitCnt_q == 4'hF)) begin
        frame.write <= rxShift_q[14];
        frame.addr  <= rxShift_q[13:7];
        frame.data  <= {rxShift_q[6:0], mosiPipe_q[1]};
      end
    end
  end

  // Reply word is loaded after a frame and shifted on rising edges
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txShift_q <= 16'h0000;
      miso      <= 1'b0;
    end else if (ce) begin
      if (frame.valid) begin
        txShift_q <= rdWord;
      end else if (csLow & rise) begin
        txShift_q <= {txShift_q[14:0], 1'b0};
      end
      miso <= txShift_q[15];
    end
  end

endmodule : spi_frame_slave
`default_nettype wire

// ==== verification/aux_io_dataready_selftest_ctrl_bench.sv ====
// Self-checking bench for level latch, I/O lines, data-ready and self-test.
// Assumes the SPI host model and a 50 MHz system clock.
`timescale 1ns/10ps
`default_nettype none
`include "aux_io_consts.svh"

module aux_io_dataready_selftest_ctrl_bench import aux_io_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        sclk, csN, mosi, miso;
  logic [1:0]  ioIn = 2'b00, ioOut, ioOe;
  logic [1:0]  alarmOwn = 2'b00, alarmLevel = 2'b00;
  logic        sampleTick = 1'b0, selfTestFail = 1'b0;
  logic [11:0] dacLevel;
  logic        selfTestRun, negRotTest, posRotTest;
  int          errCount = 0, samplesChecked = 0, runCycles = 0;

  always #10 sys_clk = ~sys_clk;

  // Length of each internal test run
  always @(posedge sys_clk) if (selfTestRun) runCycles <= runCycles + 1;

  spi_host_model spi_host_model_i (.sys_clk(sys_clk), .sclk(sclk),
    .csN(csN), .mosi(mosi), .miso(miso));

  aux_io_dataready_selftest_ctrl #(.SELFTEST_CYC(22'd50))
    aux_io_dataready_selftest_ctrl_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .ce(1'b1), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .sampleTick(sampleTick),
    .alarmOwn(alarmOwn), .alarmLevel(alarmLevel),
    .selfTestFail(selfTestFail), .dacLevel(dacLevel),
    .selfTestRun(selfTestRun), .negRotTest(negRotTest),
    .posRotTest(posRotTest));

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic closeOut();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : closeOut

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    spi_host_model_i.xfer({1'b1, a, d}, r);
  endtask : wr

  // Reply to a read arrives in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    spi_host_model_i.xfer({1'b0, a, 8'h00}, v);
    spi_host_model_i.xfer({1'b0, a, 8'h00}, v);
  endtask : rd

  // Pin control readback: outputs read one, inputs read the pin
  function automatic logic [15:0] pinExp(logic [15:0] v, logic [1:0] p);
    return {6'h00, v[9:8], 6'h00, v[1:0] | (~v[1:0] & p)};
  endfunction : pinExp

  initial begin
    logic [15:0] v, r;
    logic [11:0] dacExp;
    int          cnt;
    dacExp = 12'h000;
    void'($urandom(32'hE139));
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    ioIn   <= 2'($urandom());
    repeat (6) @(posedge sys_clk);
    // Reset values and an unmapped place
    rd(`ADDR_AUX_LEVEL, r);
    check(r, `REG_RESET);
    rd(`ADDR_MISC_CTRL, r);
    check(r, `REG_RESET);
    rd(7'h20, r);
    check(r, 16'h0000);
    // Level bytes stay off the converter until latched
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 16'hFFFF : 16'($urandom());
      wr(`ADDR_AUX_LEVEL, v[7:0]);
      check(16'(dacLevel), 16'(dacExp));
      wr(`ADDR_AUX_LEVEL + 7'h01, v[15:8]);
      check(16'(dacLevel), 16'(dacExp));
      rd(`ADDR_AUX_LEVEL, r);
      check(r, v & 16'h0FFF);
      wr(`ADDR_COMMAND, 8'h04);
      dacExp = v[11:0];
      check(16'(dacLevel), 16'(dacExp));
    end
    // Every direction pattern, random levels, unused bits set
    for (int k = 0; k < 4; k++) begin
      v = {6'h00, 2'($urandom()), 6'h00, 2'(k)};
      wr(`ADDR_PIN_IO, v[7:0] | 8'hFC);
      wr(`ADDR_PIN_IO + 7'h01, v[15:8] | 8'hFC);
      check(16'(ioOe), 16'(v[1:0]));
      check(16'(ioOut), 16'(v[9:8] & v[1:0]));
      rd(`ADDR_PIN_IO, r);
      check(r, pinExp(v, ioIn));
    end
    // Claims on the lines: data-ready over alarm over pin control
    wr(`ADDR_PIN_IO + 7'h01, 8'h00);
    wr(`ADDR_PIN_IO, 8'h03);
    alarmOwn   <= 2'b01;
    alarmLevel <= 2'b11;
    repeat (4) @(posedge sys_clk);
    check(16'({ioOe, ioOut}), 16'h000D);
    wr(`ADDR_MISC_CTRL, 8'h06);
    check(16'({ioOe, ioOut}), 16'h000C);
    wr(`ADDR_MISC_CTRL, 8'h05);
    check(16'({ioOe, ioOut}), 16'h000F);
    // Pulse on each line in each polarity, ticks 40 cycles apart
    for (int k = 0; k < 4; k++) begin
      alarmOwn <= 2'($urandom());
      wr(`ADDR_MISC_CTRL, {5'h00, 1'b1, 2'(k)});
      check(16'(ioOut[k%2]), 16'(k < 2));
      for (int t = 0; t < 2; t++) begin
        sampleTick <= 1'b1;
        @(posedge sys_clk);
        sampleTick <= 1'b0;
        if (t == 0) repeat (39) @(posedge sys_clk);
      end
      cnt = 0;
      for (int c = 0; c < 39; c++) begin
        @(negedge sys_clk);
        cnt += int'(ioOut[k%2] === (k >= 2));
      end
      check(16'(ioOe[k%2]), 16'h0001);
      check(16'(cnt >= 6 && cnt <= 14), 16'h0001);
    end
    wr(`ADDR_MISC_CTRL, 8'h00);
    // Internal test with a failing result, flag cleared by reading
    selfTestFail <= 1'b1;
    runCycles = 0;
    wr(`ADDR_MISC_CTRL + 7'h01, 8'h04);
    cnt = 0;
    while (selfTestRun === 1'b1 && cnt < 200) begin
      @(posedge sys_clk);
      cnt++;
    end
    if (cnt >= 200) begin
      errCount++;
      closeOut();
    end
    check(16'(runCycles), 16'd50);
    rd(`ADDR_STATUS, r);
    check(r, 16'h0020);
    rd(`ADDR_STATUS, r);
    check(r, 16'h0000);
    // External stimulus enables are plain levels
    wr(`ADDR_MISC_CTRL + 7'h01, 8'h02);
    check(16'({negRotTest, posRotTest}), 16'h0002);
    wr(`ADDR_MISC_CTRL + 7'h01, 8'hF9);
    check(16'({negRotTest, posRotTest}), 16'h0001);
    rd(`ADDR_MISC_CTRL, r);
    check(r, 16'h0100);
    // Reset in mid-run clears the level; host loads it again
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(16'({dacLevel, negRotTest, posRotTest}), 16'h0000);
    wr(`ADDR_AUX_LEVEL, 8'h5A);
    wr(`ADDR_COMMAND, 8'h04);
    check(16'(dacLevel), 16'h005A);
    closeOut();
  end
endmodule : aux_io_dataready_selftest_ctrl_bench
`default_nettype wire

// ==== verification/spi_host_model.sv ====
// Host side of the SPI link: 16-bit frames, mode 3, 160 ns serial clock.
// Assumes the device samples the link on its own 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
  input  wire logic sys_clk,
  output var  logic sclk,
  output var  logic csN,
  output var  logic mosi,
  input  wire logic miso
);
  // Link idles with clock high and select released
  initial begin
    sclk = 1'b1;
    csN  = 1'b1;
    mosi = 1'b0;
  end

  // One frame, MSB first; rx is what came back on miso
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge sys_clk);
    csN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge sys_clk);
      sclk <= 1'b0;
      mosi <= tx[i];
      repeat (4) @(posedge sys_clk);
      sclk <= 1'b1;
      rx[i] = miso; // Value before the device reacts to this edge
      repeat (3) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    csN  <= 1'b1;
    mosi <= ~mosi; // Released line shows no stale bit
    repeat (8) @(posedge sys_clk);
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire
